// File: bench/irb_peer.sv
// Peer repeater model framing eight bits onto the bus
`timescale 1ns/100ps
`default_nettype none
module irb_peer
(
	// Frame request and half bit period in ns
	input wire logic start,
	input wire logic [7:0] bits,
	input wire logic [7:0] half,
	// Bus clock and data, valid while drive is high
	output logic sclk,
	output logic data,
	output logic drive
);
	initial
	begin
		sclk = 1'b1;
		data = 1'b1;
		drive = 1'b0;
	end
	// Clock runs only inside the frame
	always @(posedge start)
	begin
		#13;
		drive = 1'b1;
		for (int i = 7; i >= 0; i--)
		begin
			#(half);
			sclk = 1'b0;
			data = bits[i];
			#(half);
			sclk = 1'b1;
		end
		#(half);
		drive = 1'b0;
	end
endmodule
`default_nettype wire

// File: bench/irb_port_properties.sv
// Concurrent checks on the pins of the inter-repeater bus port
`timescale 1ns/100ps
`default_nettype none
module irb_port_properties
(
	// Clock, reset and local inputs
	input wire logic clk,
	input wire logic arst_n,
	input wire logic seg_rx_active,
	input wire logic [irb_pkg::NUM_PORTS-1:0] seg_port_collisions,
	input wire logic seg_tx_collision,
	// Bus pins
	input wire logic arb_grant_in_n,
	input wire logic arb_grant_out_n,
	input wire logic bus_serial_data_o,
	input wire logic bus_serial_data_oe,
	input wire logic bus_frame_enable_n_oe,
	input wire logic bus_serial_clock_o,
	input wire logic bus_serial_clock_oe,
	input wire logic bus_activity_n_i,
	input wire logic bus_activity_n_oe,
	input wire logic multi_collision_n_i,
	input wire logic multi_collision_n_oe,
	// Status
	input wire logic core_tick,
	input wire logic bus_sourcing,
	input wire logic bus_activity_seen,
	input wire logic bus_multi_collision_seen
);
	import irb_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_busy;
		(!arb_grant_in_n) [*4];
	endsequence
	sequence s_tick_next;
		##[12:13] core_tick;
	endsequence
	property p_grant_chain;
		s_busy |-> !arb_grant_out_n;
	endproperty
	a_grant_chain: assert property (p_grant_chain) else $error("grant not passed on");
	property p_framed_oe;
		bus_serial_data_oe == bus_sourcing && bus_serial_clock_oe == bus_sourcing;
	endproperty
	a_framed_oe: assert property (p_framed_oe) else $error("bus drive mismatch");
	property p_no_win;
		s_busy |=> !$rose(bus_frame_enable_n_oe);
	endproperty
	a_no_win: assert property (p_no_win) else $error("won while busy");
	property p_data_on_fall;
		bus_sourcing && !$stable(bus_serial_data_o) |-> $fell(bus_serial_clock_o);
	endproperty
	a_data_on_fall: assert property (p_data_on_fall) else $error("data off falling edge");
	property p_activity_pull;
		seg_rx_active |=> bus_activity_n_oe;
	endproperty
	a_activity_pull: assert property (p_activity_pull) else $error("no activity pull");
	property p_activity_seen;
		(!bus_activity_n_i) [*4] |-> bus_activity_seen;
	endproperty
	a_activity_seen: assert property (p_activity_seen) else $error("activity unseen");
	property p_multi_pull;
		seg_tx_collision || $countones(seg_port_collisions) > 1 |=> multi_collision_n_oe;
	endproperty
	a_multi_pull: assert property (p_multi_pull) else $error("no multi pull");
	property p_multi_seen;
		(!multi_collision_n_i) [*4] |-> bus_multi_collision_seen;
	endproperty
	a_multi_seen: assert property (p_multi_seen) else $error("multi unseen");
	property p_tick_next;
		core_tick |-> s_tick_next;
	endproperty
	a_tick_next: assert property (p_tick_next) else $error("core tick spacing");
endmodule
bind irb_port irb_port_properties chk (
	.clk(clk),
	.arst_n(arst_n),
	.seg_rx_active(seg_rx_active),
	.seg_port_collisions(seg_port_collisions),
	.seg_tx_collision(seg_tx_collision),
	.arb_grant_in_n(arb_grant_in_n),
	.arb_grant_out_n(arb_grant_out_n),
	.bus_serial_data_o(bus_serial_data_o),
	.bus_serial_data_oe(bus_serial_data_oe),
	.bus_frame_enable_n_oe(bus_frame_enable_n_oe),
	.bus_serial_clock_o(bus_serial_clock_o),
	.bus_serial_clock_oe(bus_serial_clock_oe),
	.bus_activity_n_i(bus_activity_n_i),
	.bus_activity_n_oe(bus_activity_n_oe),
	.multi_collision_n_i(multi_collision_n_i),
	.multi_collision_n_oe(multi_collision_n_oe),
	.core_tick(core_tick),
	.bus_sourcing(bus_sourcing),
	.bus_activity_seen(bus_activity_seen),
	.bus_multi_collision_seen(bus_multi_collision_seen)
);
`default_nettype wire

// File: bench/test_irb_port.sv
// Self-checking bench: local stream out, peer frames in, shared lines
`timescale 1ns/100ps
`default_nettype none
module test_irb_port;
	import irb_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, seg_rx_active = 1'b0, seg_data_valid = 1'b0;
	logic seg_data = 1'b0, seg_port_collision = 1'b0, seg_tx_collision = 1'b0;
	logic arb_grant_in_n = 1'b1, start = 1'b0, col_pull = 1'b0, p_ck, p_d, p_dr;
	logic [NUM_PORTS-1:0] seg_port_collisions = '0;
	logic [7:0] bits = 8'h00, half = 8'h28;
	logic seg_data_ready, arb_grant_out_n, core_tick, bus_sourcing, src_underrun;
	logic bus_serial_data_o, bus_serial_data_oe, bus_frame_enable_n_o, bus_frame_enable_n_oe;
	logic bus_serial_clock_o, bus_serial_clock_oe, rx_port_collision_n_o, rx_port_collision_n_oe;
	logic bus_activity_n_o, bus_activity_n_oe, multi_collision_n_o, multi_collision_n_oe;
	logic bus_rx_frame, bus_rx_valid, bus_rx_data, bus_rx_collision;
	logic bus_activity_seen, bus_multi_collision_seen;
	int err_count = 0, n_checks = 0, seed = 32'hCB96, n, r, n_under = 0, n_hold = 0;
	logic exp_q[$];
	logic last_bit = 1'b1;
	// Pin levels from all drivers, pull-ups where nobody drives
	wire bus_serial_data_i = bus_serial_data_oe ? bus_serial_data_o : (p_dr ? p_d : 1'b1);
	wire bus_frame_enable_n_i = bus_frame_enable_n_oe ? bus_frame_enable_n_o : !p_dr;
	wire bus_serial_clock_i = bus_serial_clock_oe ? bus_serial_clock_o : (p_dr ? p_ck : 1'b1);
	wire rx_port_collision_n_i = rx_port_collision_n_oe ? rx_port_collision_n_o : !col_pull;
	wire bus_activity_n_i = !(bus_activity_n_oe || p_dr);
	wire multi_collision_n_i = !multi_collision_n_oe;
	irb_port dut (.*);
	irb_peer peer (.start(start), .bits(bits), .half(half), .sclk(p_ck), .data(p_d), .drive(p_dr));
	initial
	begin
		forever #2 clk = ~clk;
	end
	task automatic check(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Bounded wait: 0 sourcing, 1 idle, 2 all bits seen, 3 underrun seen
	task automatic await(input int w);
		int i;
		for (i = 0; i < 4000; i++)
		begin
			@(negedge clk);
			if (w == 3 ? n_under > 0 : (w < 2 ? bus_sourcing === !w : exp_q.size() == 0))
				break;
		end
		if (i == 4000)
		begin
			err_count++;
			stop_test();
		end
	endtask
	// Bits on the pins while sourcing, bits reported while listening
	// Line holds the last bit when the buffer runs dry
	always @(posedge bus_serial_clock_i)
		if (bus_sourcing === 1'b1)
		begin
			if (exp_q.size() > 0)
				last_bit = exp_q.pop_front();
			else
				n_hold++;
			check(bus_serial_data_i, last_bit);
		end
	always @(negedge clk)
		if (src_underrun === 1'b1)
			n_under++;
	always @(negedge clk)
		if (bus_rx_valid === 1'b1)
			check(bus_rx_data, exp_q.pop_front());
	initial
	begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(negedge clk);
		check(arb_grant_out_n, 1'b1);
		check(bus_serial_data_oe | bus_serial_clock_oe | rx_port_collision_n_oe, 1'b0);
		check(bus_activity_n_o | multi_collision_n_o, 1'b0);
		check(bus_activity_n_oe | multi_collision_n_oe, 1'b0);
		$display("reset done");
		// Upstream busy: local bits pile up until the buffer refuses
		@(posedge clk);
		arb_grant_in_n <= 1'b0;
		repeat (4) @(posedge clk);
		seg_rx_active <= 1'b1;
		seg_data_valid <= 1'b1;
		seg_data <= 1'($random(seed));
		n = 0;
		repeat (20)
		begin
			@(negedge clk);
			r = (seg_data_ready === 1'b1);
			if (r)
			begin
				exp_q.push_back(seg_data);
				n++;
			end
			@(posedge clk);
			// A refused bit is held until taken
			if (r)
				seg_data <= 1'($random(seed));
		end
		seg_data_valid <= 1'b0;
		check(n == FIFO_DEPTH, 1'b1);
		check(arb_grant_out_n | bus_sourcing, 1'b0);
		$display("busy done");
		// Upstream frees the chain: buffered bits leave in order, then the line holds
		arb_grant_in_n <= 1'b1;
		await(0);
		@(posedge clk);
		seg_port_collision <= 1'b1;
		repeat (4) @(negedge clk);
		check(rx_port_collision_n_i, 1'b0);
		check(bus_frame_enable_n_i, 1'b0);
		@(posedge clk);
		seg_port_collision <= 1'b0;
		await(3);
		@(posedge clk);
		seg_rx_active <= 1'b0;
		await(1);
		check(exp_q.size() == 0, 1'b1);
		check(n_under == 1 && n_hold == 1, 1'b1);
		check(bus_serial_clock_oe | rx_port_collision_n_oe, 1'b0);
		repeat (2) @(negedge clk);
		check(bus_rx_frame, 1'b0);
		$display("source done");
		// Peer frames a byte twice with a 40 ns half bit period while this port listens
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk);
			bits <= 8'($random(seed));
			half <= 8'h28;
			start <= 1'b1;
			col_pull <= 1'b1;
			@(posedge clk);
			for (int i = 7; i >= 0; i--)
				exp_q.push_back(bits[i]);
			start <= 1'b0;
			repeat (40) @(negedge clk);
			check(bus_rx_collision & bus_activity_seen, 1'b1);
			check(bus_rx_frame, 1'b1);
			check(bus_sourcing | bus_serial_data_oe, 1'b0);
			await(2);
			@(posedge clk);
			col_pull <= 1'b0;
			repeat (60) @(negedge clk);
			check(bus_rx_frame, 1'b0);
		end
		$display("listen done");
		// Transmit collision, two, one and no port collisions
		for (int k = 0; k < 4; k++)
		begin
			r = $unsigned($random(seed)) % NUM_PORTS;
			@(posedge clk);
			seg_tx_collision <= k == 0;
			seg_port_collisions <= k == 1 ? 9'h0C0 : (k == 2 ? 9'h001 << r : 9'h000);
			repeat (8) @(negedge clk);
			check(multi_collision_n_oe, k < 2);
			check(bus_multi_collision_seen, k < 2);
			check(bus_activity_n_oe, k == 1 || k == 2);
		end
		$display("collision done");
		stop_test();
	end
endmodule
`default_nettype wire

// File: hw/irb_fifo.sv
// Valid/ready FIFO with parameterised width and depth
`timescale 1ns/100ps
`default_nettype none
module irb_fifo
#(
	parameter int unsigned W = 1,
	parameter int unsigned DEPTH = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Filling side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire empty = (wr_q == rd_q);
	wire push = in_valid && !full;
	wire pop = out_ready && !empty;

	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_q[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + (AW+1)'(1);
			if (pop)
				rd_q <= rd_q + (AW+1)'(1);
		end
	end
endmodule
`default_nettype wire

// File: hw/irb_pkg.sv
// Shared constants and types for the inter-repeater bus port
package irb_pkg;

	// Fabric clock and the core rate that the bus timing is built on
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned CORE_MHZ = 20;
	localparam int unsigned CORE_ACC_W = 8;
	localparam logic [CORE_ACC_W-1:0] CORE_ACC_STEP = CORE_ACC_W'(CORE_MHZ);
	localparam logic [CORE_ACC_W-1:0] CORE_ACC_MOD = CORE_ACC_W'(CLK_MHZ);
	localparam logic [CORE_ACC_W-1:0] CORE_ACC_RST = 8'h00;

	// Stream buffer between the local segment and the bus
	localparam int unsigned FIFO_W = 1;
	localparam int unsigned FIFO_DEPTH = 16;

	// Network ports whose collisions are watched (AUI plus eight twisted pair)
	localparam int unsigned NUM_PORTS = 9;

	// Idle level of every bus pin as seen through the synchroniser
	localparam logic [6:0] PINS_IDLE = 7'h7F;

	// Bus clock idles high so the first toggle is a falling edge
	localparam logic SCLK_IDLE = 1'b1;

	// Sampled bus pins, all of them from outside the clock domain
	typedef struct packed {
		logic grant_in_n;
		logic serial_data;
		logic frame_enable_n;
		logic serial_clock;
		logic port_collision_n;
		logic activity_n;
		logic multi_collision_n;
	} irb_pins_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SOURCE,
		ST_LISTEN
	} irb_state_t;

endpackage

// File: hw/irb_port.sv
// Inter-repeater cascade bus port: arbitration chain, serial stream, shared lines
//
// Operation
// RULE_01: Pass grant chain input through to output.
// RULE_02: Board ties top chip grant input high.
// RULE_03: Drive NRZ serial data while receiving locally.
// RULE_04: Bus lines default to inputs otherwise.
// RULE_05: Assert frame enable low while receiving locally.
// RULE_06: Drive bus clock, change data on fall.
// RULE_07: Sample input data on bus clock rise.
// RULE_08: Collision line flags receiving-port collision.
// RULE_09: Pull activity low on local data/collision.
// RULE_10: Monitor shared activity line.
// RULE_11: Pull multi-collision low on tx/multi collision.
// RULE_12: Monitor shared multi-collision line.
// RULE_13: Core timing runs at 20 MHz.
// RULE_14: Only arbitration winner drives; release at end.
`timescale 1ns/100ps
`default_nettype none
module irb_port
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Local segment receive stream
	input wire logic seg_rx_active,
	input wire logic seg_data_valid,
	input wire logic seg_data,
	output logic seg_data_ready,
	// Local collision state
	input wire logic seg_port_collision,
	input wire logic [irb_pkg::NUM_PORTS-1:0] seg_port_collisions,
	input wire logic seg_tx_collision,
	// Arbitration chain
	input wire logic arb_grant_in_n,
	output logic arb_grant_out_n,
	// Serial data pin
	input wire logic bus_serial_data_i,
	output logic bus_serial_data_o,
	output logic bus_serial_data_oe,
	// Frame enable pin
	input wire logic bus_frame_enable_n_i,
	output logic bus_frame_enable_n_o,
	output logic bus_frame_enable_n_oe,
	// Bus clock pin
	input wire logic bus_serial_clock_i,
	output logic bus_serial_clock_o,
	output logic bus_serial_clock_oe,
	// Receiving-port collision pin
	input wire logic rx_port_collision_n_i,
	output logic rx_port_collision_n_o,
	output logic rx_port_collision_n_oe,
	// Open-drain activity pin
	input wire logic bus_activity_n_i,
	output logic bus_activity_n_o,
	output logic bus_activity_n_oe,
	// Open-drain multi-collision pin
	input wire logic multi_collision_n_i,
	output logic multi_collision_n_o,
	output logic multi_collision_n_oe,
	// Status towards the repeater core
	output logic core_tick,
	output logic bus_sourcing,
	output logic bus_rx_frame,
	output logic bus_rx_valid,
	output logic bus_rx_data,
	output logic bus_rx_collision,
	output logic bus_activity_seen,
	output logic bus_multi_collision_seen,
	output logic src_underrun
);
	import irb_pkg::*;

	// True when two or more ports report a collision
	function automatic logic more_than_one(input logic [NUM_PORTS-1:0] v);
		logic [NUM_PORTS-1:0] low_cleared;
		low_cleared = v & (v - NUM_PORTS'(1));
		return |low_cleared;
	endfunction

	// Synchronised pins
	irb_pins_t pins_raw;
	irb_pins_t pins_s;

	assign pins_raw.grant_in_n = arb_grant_in_n;
	assign pins_raw.serial_data = bus_serial_data_i;
	assign pins_raw.frame_enable_n = bus_frame_enable_n_i;
	assign pins_raw.serial_clock = bus_serial_clock_i;
	assign pins_raw.port_collision_n = rx_port_collision_n_i;
	assign pins_raw.activity_n = bus_activity_n_i;
	assign pins_raw.multi_collision_n = multi_collision_n_i;

	irb_sync #(
		.W($bits(irb_pins_t)),
		.RST_VAL(PINS_IDLE)
	) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	// Stream buffer between segment and bus
	logic fifo_out_valid;
	logic [FIFO_W-1:0] fifo_out_data;
	wire fifo_pop;

	irb_fifo #(
		.W(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.arst_n(arst_n),
		.in_valid(seg_data_valid),
		.in_data(seg_data),
		.in_ready(seg_data_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_pop)
	);

	// State
	irb_state_t state_q;
	irb_state_t state_d;
	logic [CORE_ACC_W-1:0] acc_q;
	logic [CORE_ACC_W-1:0] acc_d;
	logic tick_q;
	logic sclk_q;
	logic sdata_q;
	logic drive_q;
	logic frame_n_q;
	logic col_n_q;
	logic act_oe_q;
	logic multi_oe_q;
	logic grant_out_n_q;
	logic sclk_prev_q;
	logic rx_valid_q;
	logic rx_data_q;
	logic rx_col_q;
	logic underrun_q;
	// Two-cycle history of our own drive
	logic [1:0] echo_q;

	// Fractional accumulator gives an exact 20 MHz average tick
	wire [CORE_ACC_W:0] acc_sum = {1'b0, acc_q} + {1'b0, CORE_ACC_STEP};
	wire acc_wrap = acc_sum >= {1'b0, CORE_ACC_MOD};
	assign acc_d = acc_wrap ? CORE_ACC_W'(acc_sum - {1'b0, CORE_ACC_MOD}) : acc_sum[CORE_ACC_W-1:0];

	// Arbitration decode
	wire upstream_busy = !pins_s.grant_in_n;
	wire win = seg_rx_active && !upstream_busy;
	wire grant_out_n_d = !(upstream_busy || seg_rx_active || state_q == ST_SOURCE);

	// Source side clocking
	wire sourcing = (state_q == ST_SOURCE);
	wire sclk_fall = sourcing && tick_q && sclk_q;
	wire frame_done = sclk_fall && !seg_rx_active && !fifo_out_valid;
	assign fifo_pop = sclk_fall && fifo_out_valid;

	// Listen side sampling
	wire listening = (state_q == ST_LISTEN);
	wire sclk_rise = pins_s.serial_clock && !sclk_prev_q;
	wire frame_seen = !pins_s.frame_enable_n;

	// Own frame enable lingers in the synchroniser after release
	wire echo_guard = |echo_q;
	// Listen only to a frame that another chip drives
	wire foreign_frame = frame_seen && !echo_guard && !drive_q;

	// Local activity and collision decode
	wire local_activity = seg_rx_active || (|seg_port_collisions);
	wire local_multi = seg_tx_collision || more_than_one(seg_port_collisions);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (win)
					state_d = ST_SOURCE; // [RULE_14]
				else if (foreign_frame)
					state_d = ST_LISTEN;
			end
			ST_SOURCE:
			begin
				if (frame_done)
					state_d = ST_IDLE; // [RULE_14]
			end
			ST_LISTEN:
			begin
				if (!frame_seen)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	// State and core tick
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= ST_IDLE;
			acc_q <= CORE_ACC_RST;
			tick_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			acc_q <= acc_d; // [RULE_13]
			tick_q <= acc_wrap; // [RULE_13]
		end
	end

	// Arbitration chain output
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			grant_out_n_q <= 1'b1;
		else
			grant_out_n_q <= grant_out_n_d; // [RULE_01]
	end

	// Bus clock and data when sourcing
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_q <= SCLK_IDLE;
			sdata_q <= 1'b1;
		end
		else if (!sourcing)
		begin
			sclk_q <= SCLK_IDLE;
			sdata_q <= 1'b1;
		end
		else
		begin
			if (tick_q)
				sclk_q <= !sclk_q; // [RULE_06]
			if (fifo_pop)
				sdata_q <= fifo_out_data[0]; // [RULE_03] [RULE_06]
		end
	end

	// Output enables and driven levels of the framed lines
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			drive_q <= 1'b0;
			frame_n_q <= 1'b1;
			col_n_q <= 1'b1;
		end
		else
		begin
			drive_q <= (state_d == ST_SOURCE); // [RULE_04] [RULE_14]
			frame_n_q <= !(state_d == ST_SOURCE); // [RULE_05]
			col_n_q <= !(seg_port_collision && state_d == ST_SOURCE); // [RULE_08]
		end
	end

	// Shared open-drain lines
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			act_oe_q <= 1'b0;
			multi_oe_q <= 1'b0;
		end
		else
		begin
			act_oe_q <= local_activity; // [RULE_09]
			multi_oe_q <= local_multi; // [RULE_11]
		end
	end

	// Receive from another chip on the bus
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_prev_q <= 1'b1;
			rx_valid_q <= 1'b0;
			rx_data_q <= 1'b1;
			rx_col_q <= 1'b0;
		end
		else
		begin
			sclk_prev_q <= pins_s.serial_clock;
			rx_valid_q <= listening && frame_seen && sclk_rise; // [RULE_07]
			if (listening && frame_seen && sclk_rise)
				rx_data_q <= pins_s.serial_data; // [RULE_07]
			rx_col_q <= listening && !pins_s.port_collision_n; // [RULE_08]
		end
	end

	// Buffer ran dry while the segment still delivers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			underrun_q <= 1'b0;
		else
			underrun_q <= sclk_fall && !fifo_out_valid && seg_rx_active;
	end

	// Recent sourcing history, masks the echo of our own frame
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			echo_q <= 2'h0;
		else
			echo_q <= {echo_q[0], drive_q}; // [RULE_14]
	end

	// Pin outputs
	assign arb_grant_out_n = grant_out_n_q;
	assign bus_serial_data_o = sdata_q;
	assign bus_serial_data_oe = drive_q; // [RULE_03] [RULE_04]
	assign bus_frame_enable_n_o = frame_n_q;
	assign bus_frame_enable_n_oe = drive_q; // [RULE_05] [RULE_04]
	assign bus_serial_clock_o = sclk_q;
	assign bus_serial_clock_oe = drive_q; // [RULE_06] [RULE_04]
	assign rx_port_collision_n_o = col_n_q;
	assign rx_port_collision_n_oe = drive_q; // [RULE_08] [RULE_04]
	assign bus_activity_n_o = 1'b0;
	assign bus_activity_n_oe = act_oe_q; // [RULE_09]
	assign multi_collision_n_o = 1'b0;
	assign multi_collision_n_oe = multi_oe_q; // [RULE_11]

	// Status outputs
	assign core_tick = tick_q;
	assign bus_sourcing = drive_q;
	assign bus_rx_frame = listening;
	assign bus_rx_valid = rx_valid_q;
	assign bus_rx_data = rx_data_q;
	assign bus_rx_collision = rx_col_q;
	assign bus_activity_seen = !pins_s.activity_n; // [RULE_10]
	assign bus_multi_collision_seen = !pins_s.multi_collision_n; // [RULE_12]
	assign src_underrun = underrun_q;
endmodule
`default_nettype wire

// File: hw/irb_sync.sv
// Two-flop synchroniser for a group of pins
`timescale 1ns/100ps
`default_nettype none
module irb_sync
#(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '1
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Asynchronous in, synchronous out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule
`default_nettype wire
